// *** hdl/isc_idle_ctrl.sv ***
// Idle standby controller with APB register access
`timescale 1ns/100ps
`include "isc_regs.svh"
// Function
// - Idle stops main oscillator only; CPU and peripheral clocks gated.
// - Idle halts CPU; port output latches hold their entry values.
// - 16-bit counter runs only on watch output, watch on subsystem clock.
// - 8-bit event counters run only with external timer inputs selected.
// - Extra 8-bit timers run only with their external inputs selected.
// - Watch timer runs only when clocked from subsystem clock.
// - Real-time port needs external trigger or external timer clocks.
// - Serial runs only on external clock; I2C mode stops while idle.
// - External bus lines float in idle; wait input state is retained.
// - Only external and watch interrupts end idle as interrupts.
// - Other interrupt requests stay pending until idle is released.
// - Valid NMI edge per edge enable registers releases idle.
// - NMI release branches if acknowledgeable, else after return.
// - Unmasked external edge, no macro service, restarts oscillator.
// - Unmasked watch overflow without macro service releases idle.
// - Maskable release services if enabled and acceptable, else resumes.
// - Oscillator off in reset; restarts after, waits stabilization time.
// - Reset ending idle keeps data memory contents.
module isc_idle_ctrl #(
    parameter int STAB_CYCLES = `ISC_STAB_US * `ISC_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic nmi_in,
    input wire logic [5:0] external_interrupt_inputs,
    input wire logic watch_timer_interrupt,
    input wire logic interrupt_enable_flag,
    input wire logic int_ackable,
    input wire logic nmi_ackable,
    input wire logic return_from_interrupt_instr,
    input wire logic wait_in,
    output logic main_osc_en,
    output logic sub_osc_en,
    output isc_pkg::isc_run_t run_o,
    output logic port_hold,
    output logic bus_oe,
    output logic wait_state,
    output logic pending_hold,
    output logic nmi_branch,
    output logic isr_branch,
    output logic resume_next,
    output logic ram_retain
);
    localparam int CW = $clog2(STAB_CYCLES + 1);
    localparam logic [CW-1:0] STAB_LOAD = CW'(STAB_CYCLES - 1);

    // ==========================================================
    // Registers and state
    isc_pkg::isc_state_t state_reg, state_next;
    isc_pkg::isc_cause_t cause_reg, cause_next;
    isc_pkg::isc_run_t run_reg, run_next;
    logic [7:0] standby_ctl_reg;
    logic [6:0] egr_reg, egf_reg, mask_reg, msvc_reg, prev_reg;
    logic [6:0] wake_src_reg;
    logic [9:0] cfg_reg;
    logic [CW-1:0] cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic main_osc_reg, sub_osc_reg, port_hold_reg, bus_oe_reg;
    logic wait_reg, pending_reg, nmi_br_reg, isr_br_reg, resume_reg;
    logic retain_reg, nmi_def_reg;

    // ==========================================================
    // APB decode
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_reg;
    wire wr = acc & pwrite;
    wire hit_standby = paddr == `ISC_ADDR_STANDBY;
    wire hit_egr = paddr == `ISC_ADDR_EGR;
    wire hit_egf = paddr == `ISC_ADDR_EGF;
    wire hit_mask = paddr == `ISC_ADDR_MASK;
    wire hit_msvc = paddr == `ISC_ADDR_MSVC;
    wire hit_cfg = paddr == `ISC_ADDR_CFG;
    wire hit_stat = paddr == `ISC_ADDR_STAT;
    wire mapped = hit_standby | hit_egr | hit_egf | hit_mask | hit_msvc |
        hit_cfg | hit_stat;
    wire [31:0] stat_word = {19'h00000, wake_src_reg, 1'b0, nmi_def_reg,
        retain_reg, cnt_reg != '0, main_osc_reg,
        state_reg == isc_pkg::ST_IDLE};
    wire [31:0] rd_mux =
        hit_standby ? {24'h000000, standby_ctl_reg} :
        hit_egr ? {25'h0000000, egr_reg} :
        hit_egf ? {25'h0000000, egf_reg} :
        hit_mask ? {25'h0000000, mask_reg} :
        hit_msvc ? {25'h0000000, msvc_reg} :
        hit_cfg ? {22'h000000, cfg_reg} :
        hit_stat ? stat_word : 32'h00000000;
    wire idle_wr = wr & hit_standby & pwdata[7:0] == `ISC_CODE_IDLE &
        state_reg == isc_pkg::ST_RUN;
    wire retain_clr = wr & hit_stat & pwdata[`ISC_STAT_RETAIN];

    // ==========================================================
    // Edge detection per source
    wire [6:0] src = {nmi_in, external_interrupt_inputs};
    logic [6:0] edge_ok;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_edge
            assign edge_ok[gi] = (src[gi] & ~prev_reg[gi] & egr_reg[gi]) |
                (~src[gi] & prev_reg[gi] & egf_reg[gi]);
        end
    endgenerate
    wire nmi_wake = edge_ok[`ISC_NMI_BIT];
    wire [5:0] int_hit = edge_ok[5:0] & ~mask_reg[5:0] & ~msvc_reg[5:0];
    wire wt_wake = watch_timer_interrupt & ~mask_reg[`ISC_WT_BIT] &
        ~msvc_reg[`ISC_WT_BIT];
    wire any_wake = nmi_wake | (|int_hit) | wt_wake;
    wire cnt_done = cnt_reg == '0;
    wire idle_now = state_reg == isc_pkg::ST_IDLE;
    wire wake_now = state_reg == isc_pkg::ST_WAKE;
    wire leave_wake = wake_now & cnt_done & reset_pin_n;
    wire disp_nmi = leave_wake & cause_reg == isc_pkg::CS_NMI;
    wire disp_mask = leave_wake & cause_reg == isc_pkg::CS_MASK;
    wire int_go = interrupt_enable_flag & int_ackable;
    wire nmi_late = nmi_def_reg & return_from_interrupt_instr & nmi_ackable;

    // ==========================================================
    // State machine
    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        case (state_reg)
            isc_pkg::ST_RUN: begin
                if (!reset_pin_n) begin
                    state_next = isc_pkg::ST_PIN_RST;
                end else if (idle_wr) begin
                    state_next = isc_pkg::ST_IDLE;
                    cause_next = isc_pkg::CS_NONE;
                end
            end
            isc_pkg::ST_IDLE: begin
                if (!reset_pin_n) begin
                    state_next = isc_pkg::ST_PIN_RST;
                end else if (any_wake) begin
                    state_next = isc_pkg::ST_WAKE;
                    cause_next = nmi_wake ? isc_pkg::CS_NMI :
                        isc_pkg::CS_MASK;
                end
            end
            isc_pkg::ST_WAKE: begin
                if (!reset_pin_n) begin
                    state_next = isc_pkg::ST_PIN_RST;
                end else if (cnt_done) begin
                    state_next = isc_pkg::ST_RUN;
                end
            end
            isc_pkg::ST_PIN_RST: begin
                if (reset_pin_n) begin
                    state_next = isc_pkg::ST_RST_STAB;
                end
            end
            isc_pkg::ST_RST_STAB: begin
                if (!reset_pin_n) begin
                    state_next = isc_pkg::ST_PIN_RST;
                end else if (cnt_done) begin
                    state_next = isc_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = isc_pkg::ST_RUN;
            end
        endcase
    end

    // ==========================================================
    // Clock and peripheral gating
    wire nx_run = state_next == isc_pkg::ST_RUN;
    wire nx_idle = state_next == isc_pkg::ST_IDLE |
        state_next == isc_pkg::ST_WAKE;
    wire nx_osc = nx_run | state_next == isc_pkg::ST_WAKE |
        state_next == isc_pkg::ST_RST_STAB;
    wire [1:0] tm8_ext = cfg_reg[`ISC_CFG_TM8_EXT+:2];
    always_comb begin
        run_next.cpu = nx_run;
        run_next.periph = nx_run;
        run_next.tm16 = nx_run | (nx_idle & cfg_reg[`ISC_CFG_TM16_WT] &
            cfg_reg[`ISC_CFG_WT_SUB]);
        run_next.tm8 = {2{nx_run}} | ({2{nx_idle}} & tm8_ext);
        run_next.tmr56 = {2{nx_run}} |
            ({2{nx_idle}} & cfg_reg[`ISC_CFG_TMR56_EXT+:2]);
        run_next.watch = nx_run | (nx_idle & cfg_reg[`ISC_CFG_WT_SUB]);
        run_next.rtp = nx_run | (nx_idle & (cfg_reg[`ISC_CFG_RTP_EXT] |
            &tm8_ext));
        run_next.serial = nx_run | (nx_idle & cfg_reg[`ISC_CFG_SER_EXT] &
            ~cfg_reg[`ISC_CFG_SER_I2C]);
    end

    // ==========================================================
    // Clocked logic
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= isc_pkg::ST_RUN;
            cause_reg <= isc_pkg::CS_NONE;
            run_reg <= '0;
            cnt_reg <= '0;
            prev_reg <= 7'h00;
            wake_src_reg <= 7'h00;
        end else begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            run_reg <= run_next;
            prev_reg <= src;
            if (state_next != state_reg &&
                (state_next == isc_pkg::ST_WAKE ||
                state_next == isc_pkg::ST_RST_STAB)) begin
                cnt_reg <= STAB_LOAD;
            end else if (!cnt_done) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (idle_now && any_wake) begin
                wake_src_reg <= {nmi_wake, int_hit};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            standby_ctl_reg <= `ISC_RST_STANDBY;
            egr_reg <= `ISC_RST_EDGE;
            egf_reg <= `ISC_RST_EDGE;
            mask_reg <= `ISC_RST_MASK;
            msvc_reg <= `ISC_RST_MSVC;
            cfg_reg <= `ISC_RST_CFG;
        end else if (wr) begin
            if (hit_standby) standby_ctl_reg <= pwdata[7:0];
            if (hit_egr) egr_reg <= pwdata[6:0];
            if (hit_egf) egf_reg <= pwdata[6:0];
            if (hit_mask) mask_reg <= pwdata[6:0];
            if (hit_msvc) msvc_reg <= pwdata[6:0];
            if (hit_cfg) cfg_reg <= pwdata[9:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup) prdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            main_osc_reg <= 1'b0;
            sub_osc_reg <= 1'b0;
            port_hold_reg <= 1'b0;
            bus_oe_reg <= 1'b0;
            wait_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            main_osc_reg <= nx_osc;
            sub_osc_reg <= 1'b1;
            port_hold_reg <= ~nx_run;
            bus_oe_reg <= nx_run & cfg_reg[`ISC_CFG_EXT_BUS];
            if (nx_run) wait_reg <= wait_in;
            pending_reg <= ~nx_run;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            nmi_br_reg <= 1'b0;
            isr_br_reg <= 1'b0;
            resume_reg <= 1'b0;
            nmi_def_reg <= 1'b0;
            retain_reg <= 1'b0;
        end else begin
            // NMI branch now or after return
            nmi_br_reg <= (disp_nmi & nmi_ackable) | nmi_late;
            if (disp_nmi && !nmi_ackable) begin
                nmi_def_reg <= 1'b1;
            end else if (nmi_late) begin
                nmi_def_reg <= 1'b0;
            end
            isr_br_reg <= disp_mask & int_go;
            resume_reg <= (disp_mask & ~int_go) |
                (disp_nmi & ~nmi_ackable);
            if (idle_now && !reset_pin_n) begin
                retain_reg <= 1'b1;
            end else if (retain_clr) begin
                retain_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign main_osc_en = main_osc_reg;
    assign sub_osc_en = sub_osc_reg;
    assign run_o = run_reg;
    assign port_hold = port_hold_reg;
    assign bus_oe = bus_oe_reg;
    assign wait_state = wait_reg;
    assign pending_hold = pending_reg;
    assign nmi_branch = nmi_br_reg;
    assign isr_branch = isr_br_reg;
    assign resume_next = resume_reg;
    assign ram_retain = retain_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_enter_idle;
        idle_wr && reset_pin_n ##1 idle_now;
    endsequence
    sequence s_stab_wait;
        wake_now && !cnt_done;
    endsequence

    AST_IDLE_ENTRY: assert property (
        idle_wr && reset_pin_n |=> idle_now)
        else $error("idle code did not enter idle");
    AST_IDLE_CLOCKS: assert property (s_enter_idle |->
        !main_osc_en && sub_osc_en && !run_o.cpu && !run_o.periph)
        else $error("idle clocks wrong");
    AST_PORT_HOLD: assert property (idle_now |-> port_hold)
        else $error("port latch not held");
    AST_WATCH_GATE: assert property (idle_now |->
        run_o.watch == cfg_reg[`ISC_CFG_WT_SUB])
        else $error("watch gate wrong");
    AST_TM16_GATE: assert property (idle_now && $stable(cfg_reg) |->
        run_o.tm16 == (cfg_reg[0] & cfg_reg[1]))
        else $error("16-bit counter gate wrong");
    AST_SER_GATE: assert property (idle_now &&
        cfg_reg[`ISC_CFG_SER_I2C] |-> !run_o.serial)
        else $error("I2C serial ran in idle");
    AST_BUS_FLOAT: assert property (idle_now |->
        !bus_oe && $stable(wait_state))
        else $error("bus driven in idle");
    AST_NMI_WAKE: assert property (
        idle_now && nmi_wake && reset_pin_n |=>
        wake_now && cause_reg == isc_pkg::CS_NMI)
        else $error("NMI edge did not release idle");
    AST_NO_WAKE: assert property (
        idle_now && !any_wake && reset_pin_n |=> idle_now)
        else $error("idle left without source");
    AST_STAB_GATE: assert property (s_stab_wait |-> !run_o.cpu &&
        main_osc_en && pending_hold)
        else $error("CPU ran before stable");
    AST_RESUME: assert property (disp_mask && !int_go |=>
        resume_next && !isr_branch ##1 !resume_next)
        else $error("resume pulse wrong");
    AST_NMI_LATE: assert property (nmi_late |=>
        nmi_branch && !nmi_def_reg)
        else $error("deferred NMI not taken");
    AST_RST_OSC: assert property (!reset_pin_n |=>
        !main_osc_en [*1] ##0 !run_o.cpu)
        else $error("oscillator ran in reset");
    AST_RETAIN: assert property (
        idle_now && !reset_pin_n |=> ram_retain)
        else $error("retain flag not set");
endmodule : isc_idle_ctrl

// *** inc/isc_pkg.sv ***
// Types shared by the idle standby controller
package isc_pkg;
    typedef enum logic [2:0] {
        ST_RUN, ST_IDLE, ST_WAKE, ST_PIN_RST, ST_RST_STAB
    } isc_state_t;
    typedef enum logic [1:0] {CS_NONE, CS_NMI, CS_MASK} isc_cause_t;
    typedef struct packed {
        logic cpu;
        logic periph;
        logic tm16;
        logic [1:0] tm8;
        logic [1:0] tmr56;
        logic watch;
        logic rtp;
        logic serial;
    } isc_run_t;
endpackage : isc_pkg

// *** inc/isc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH
`define ISC_ADDR_STANDBY 8'h00
`define ISC_ADDR_EGR 8'h04
`define ISC_ADDR_EGF 8'h08
`define ISC_ADDR_MASK 8'h0C
`define ISC_ADDR_MSVC 8'h10
`define ISC_ADDR_CFG 8'h14
`define ISC_ADDR_STAT 8'h18
`define ISC_CODE_IDLE 8'h77
`define ISC_RST_STANDBY 8'h00
`define ISC_RST_EDGE 7'h00
`define ISC_RST_MASK 7'h7F
`define ISC_RST_MSVC 7'h00
`define ISC_RST_CFG 10'h000
`define ISC_NMI_BIT 6
`define ISC_WT_BIT 6
`define ISC_CFG_TM16_WT 0
`define ISC_CFG_WT_SUB 1
`define ISC_CFG_TM8_EXT 2
`define ISC_CFG_TMR56_EXT 4
`define ISC_CFG_RTP_EXT 6
`define ISC_CFG_SER_EXT 7
`define ISC_CFG_SER_I2C 8
`define ISC_CFG_EXT_BUS 9
`define ISC_STAT_RETAIN 3
`define ISC_CLK_MHZ 200
`define ISC_STAB_US 41900
`endif

// *** tb/isc_cpu_model.sv ***
// CPU core and interrupt source model facing the idle controller
`timescale 1ns/100ps
module isc_cpu_model (
    input wire logic clk_sys,
    output logic nmi_in,
    output logic [5:0] external_interrupt_inputs,
    output logic watch_timer_interrupt,
    output logic interrupt_enable_flag,
    output logic int_ackable,
    output logic nmi_ackable,
    output logic return_from_interrupt_instr,
    output logic wait_in
);
    // ==========================================
    // Idle levels
    initial begin
        nmi_in = 1'b0;
        external_interrupt_inputs = 6'h00;
        watch_timer_interrupt = 1'b0;
        interrupt_enable_flag = 1'b0;
        int_ackable = 1'b0;
        nmi_ackable = 1'b0;
        return_from_interrupt_instr = 1'b0;
        wait_in = 1'b0;
    end

    // ==========================================
    // CPU status levels
    // enable flag and ack state
    task set_cpu(input logic en, input logic ia, input logic na,
            input logic w);
        @(posedge clk_sys);
        interrupt_enable_flag <= en;
        int_ackable <= ia;
        nmi_ackable <= na;
        wait_in <= w;
    endtask : set_cpu

    // ==========================================
    // Interrupt sources
    task flip_nmi();
        @(posedge clk_sys);
        nmi_in <= ~nmi_in;
    endtask : flip_nmi

    task flip_ext(input int i);
        @(posedge clk_sys);
        external_interrupt_inputs[i] <= ~external_interrupt_inputs[i];
    endtask : flip_ext

    task pulse_wt();
        @(posedge clk_sys);
        watch_timer_interrupt <= 1'b1;
        @(posedge clk_sys);
        watch_timer_interrupt <= 1'b0;
    endtask : pulse_wt

    task ret_int();
        @(posedge clk_sys);
        return_from_interrupt_instr <= 1'b1;
        nmi_ackable <= 1'b1;
        @(posedge clk_sys);
        return_from_interrupt_instr <= 1'b0;
    endtask : ret_int
endmodule : isc_cpu_model

// *** tb/tb.sv ***
// Self-checking bench of the idle standby controller
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] A_CTL = 8'h00;
    localparam logic [7:0] A_RISE = 8'h04;
    localparam logic [7:0] A_FALL = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0C;
    localparam logic [7:0] A_CFG = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    logic clk_sys, resetn, psel, penable, pwrite, reset_pin_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic pready, pslverr, rd_err, main_osc_en, sub_osc_en, port_hold;
    logic bus_oe, wait_state, pending_hold, nmi_branch, isr_branch;
    logic resume_next, ram_retain, nmi_in, wti, int_en, ia, na, rti, wait_in;
    logic [5:0] ext_in;
    isc_pkg::isc_run_t run_o;
    int miscompares = 0;
    int samples_checked = 0;

    isc_idle_ctrl #(.STAB_CYCLES(4)) u_dut (.clk_sys(clk_sys),
        .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .nmi_in(nmi_in), .external_interrupt_inputs(ext_in),
        .watch_timer_interrupt(wti), .interrupt_enable_flag(int_en),
        .int_ackable(ia), .nmi_ackable(na),
        .return_from_interrupt_instr(rti), .wait_in(wait_in),
        .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .run_o(run_o),
        .port_hold(port_hold), .bus_oe(bus_oe), .wait_state(wait_state),
        .pending_hold(pending_hold), .nmi_branch(nmi_branch),
        .isr_branch(isr_branch), .resume_next(resume_next),
        .ram_retain(ram_retain));
    isc_cpu_model u_cpu (.clk_sys(clk_sys), .nmi_in(nmi_in),
        .external_interrupt_inputs(ext_in), .watch_timer_interrupt(wti),
        .interrupt_enable_flag(int_en), .int_ackable(ia), .nmi_ackable(na),
        .return_from_interrupt_instr(rti), .wait_in(wait_in));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ==========================================
    // Shared tasks
    task tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked,
            miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Wait for the CPU clock gate, bounded
    task wait_cpu(input logic v);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            #1;
            if (run_o.cpu === v) break;
        end
        if (n == 50) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : wait_cpu

    task enter_idle();
        apb(1'b1, A_CTL, 32'h0000_0077);
        wait_cpu(1'b0);
    endtask : enter_idle

    // ==========================================
    // Scenarios
    task t_regs();
        #1;
        chk(sub_osc_en, 1'b1);
        apb(1'b0, A_MASK, 32'h0);
        chk(rd_data, 32'h0000_007F);
        apb(1'b1, A_FALL, 32'h0000_002A);
        apb(1'b0, A_FALL, 32'h0);
        chk(rd_data, 32'h0000_002A);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd_err, 1'b1);
        chk(rd_data, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs

    task t_nmi(input logic ack);
        u_cpu.set_cpu(1'b1, 1'b1, ack, 1'b1);
        apb(1'b1, A_CFG, 32'h0000_02FF);
        apb(1'b1, A_RISE, 32'h0000_0040);
        enter_idle();
        chk(run_o, 10'h0FF);
        chk(main_osc_en, 1'b0);
        chk(sub_osc_en, 1'b1);
        chk(port_hold, 1'b1);
        chk(bus_oe, 1'b0);
        chk(pending_hold, 1'b1);
        u_cpu.set_cpu(1'b1, 1'b1, ack, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk(wait_state, 1'b1);
        u_cpu.flip_nmi();
        repeat (2) @(posedge clk_sys);
        #1;
        chk(main_osc_en, 1'b1);
        chk(run_o.cpu, 1'b0);
        wait_cpu(1'b1);
        chk({nmi_branch, resume_next}, {ack, ~ack});
        if (!ack) begin
            u_cpu.ret_int();
            #1;
            chk(nmi_branch, 1'b1);
        end
        u_cpu.flip_nmi();
        $display("test nmi done");
    endtask : t_nmi

    task t_ext();
        u_cpu.set_cpu(1'b1, 1'b1, 1'b0, 1'b0);
        apb(1'b1, A_CFG, 32'h0000_0001);
        apb(1'b1, A_RISE, 32'h0000_0003);
        apb(1'b1, A_MASK, 32'h0000_007E);
        enter_idle();
        chk(run_o, 10'h000);
        u_cpu.flip_ext(1);
        repeat (8) @(posedge clk_sys);
        chk({run_o.cpu, main_osc_en}, 2'b00);
        u_cpu.flip_ext(0);
        wait_cpu(1'b1);
        chk({isr_branch, resume_next}, 2'b10);
        u_cpu.flip_ext(0);
        u_cpu.flip_ext(1);
        $display("test ext done");
    endtask : t_ext

    task t_watch();
        u_cpu.set_cpu(1'b0, 1'b1, 1'b0, 1'b0);
        apb(1'b1, A_CFG, 32'h0000_0182);
        apb(1'b1, A_MASK, 32'h0000_003F);
        enter_idle();
        chk(run_o, 10'h004);
        u_cpu.pulse_wt();
        wait_cpu(1'b1);
        chk({isr_branch, resume_next}, 2'b01);
        $display("test watch done");
    endtask : t_watch

    task t_pin();
        enter_idle();
        @(posedge clk_sys);
        reset_pin_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({main_osc_en, run_o}, 11'h000);
        @(posedge clk_sys);
        reset_pin_n <= 1'b1;
        wait_cpu(1'b1);
        chk(main_osc_en, 1'b1);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd_data[3], 1'b1);
        apb(1'b1, A_STAT, 32'h0000_0008);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd_data[3], 1'b0);
        $display("test pin done");
    endtask : t_pin

    // ==========================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        reset_pin_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_nmi(1'b1);
        t_nmi(1'b0);
        t_ext();
        t_watch();
        t_pin();
        tally_and_finish();
    end
endmodule : tb
